// ===== include/sdram_timing_pkg.sv
// constants, field layout and carrier types for the sdram timing control block
// assumes a 16-bit control register reached over a 32-bit classic wishbone slave
//
// Notes on behaviour
// - area-2 latency code 00/01 gives one cycle, 10 two, 11 three; reset three.
// - area-0 first cycle waits 0,1,2,3,4,6,8,10; code 000 ignores wait pin.
// - area-0 burst beats take 2,2,3,4,4,6,8,10 states; wait pin always honoured (code ignores it at code 000).
// - memory control register clears only on power-on reset, kept otherwise.
// - normal precharge to bank-active gap is 1..4 cycles by precharge field.
// - gap one less after refresh precharge or bank-mode precharge; 2,5,8,11 after self-refresh.
// - read/write command follows bank activation by 1..4 cycles by row-to-col field.
// - after write, next bank-active waits precharge gap plus write recovery 1..3.
// - after auto-refresh, bank-active waits precharge gap plus 2..5 cycles.
// - bank-mode bit 0 selects auto-precharge, 1 keeps banks open.
// - four-bit multiplex field chooses the row/column address split.
// - refresh-enable bit, reset clear, turns sdram refresh on.
// - auto-refresh request during a bus cycle waits until the cycle ends (code raises it regardless of busCycleActive).
// - self-refresh entered after running cycle; requests discarded while in it.

package sdram_timing_pkg;

	localparam logic [3:0] MEM_CTRL_ADDR = 4'h0;
	localparam logic [3:0] WAIT_CTRL_ADDR = 4'h4;
	localparam logic [3:0] STATUS_ADDR = 4'h8;
	localparam logic [15:0] MEM_CTRL_RESET = 16'h0000;
	localparam logic [4:0] WAIT_CTRL_RESET = 5'h1F;
	localparam int PRECHARGE_POS = 14;
	localparam int ROW_COL_POS = 12;
	localparam int WRITE_REC_POS = 10;
	localparam int REFRESH_ACT_POS = 8;
	localparam int BANK_MODE_POS = 7;
	localparam int ADDR_SPLIT_POS = 3;
	localparam int REFRESH_ON_POS = 2;
	localparam int REFRESH_KIND_POS = 1;
	localparam logic [15:0] MEM_CTRL_WRITABLE = 16'hFFFE;
	localparam logic [3:0] SPLIT_A9_16 = 4'h4;
	localparam logic [3:0] SPLIT_A10_16 = 4'h5;
	localparam logic [3:0] SPLIT_A9_32 = 4'h7;
	localparam logic [3:0] SPLIT_A10_4B = 4'hD;
	localparam logic [3:0] SPLIT_A11_4B = 4'hE;
	localparam logic [3:0] SELF_EXIT_BASE = 4'h2;
	localparam logic [3:0] SELF_EXIT_STEP = 4'h3;
	localparam logic [3:0] REFRESH_ACT_BASE = 4'h2;

	typedef struct packed {
		logic [1:0] prechargeGap;
		logic [1:0] rowToColDelay;
		logic [1:0] writeRecovery;
		logic [1:0] refreshActiveGap;
		logic bankOpenMode;
		logic [3:0] addrSplit;
		logic refreshOn;
		logic refreshKind;
		logic spare;
	} mem_ctrl_t;

	typedef struct packed {
		logic [3:0] casLatency;
		logic [3:0] area0FirstWaits;
		logic area0WaitPinUsed;
		logic [3:0] area0BurstStates;
	} wait_timing_t;

	typedef enum logic [2:0] {
		GAP_NORMAL,
		GAP_REFRESH_PRE,
		GAP_BANK_PRE,
		GAP_WRITE,
		GAP_AUTO_REFRESH,
		GAP_SELF_EXIT
	} gap_kind_t;

endpackage

// ===== rtl/gap_counter.sv
// countdown holding off a memory command for a loaded number of cycles
// assumes load and a nonzero count come from the same clock domain
`timescale 1ns/10ps
`default_nettype none

module gap_counter
	import sdram_timing_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	input wire logic clock, // bus clock
	input wire logic srst, // synchronous reset
	input wire logic load, // start a new gap
	input wire logic [WIDTH-1:0] count, // cycles to hold off
	output logic busy // gap still running
);

	logic [WIDTH-1:0] remain;
	logic [WIDTH-1:0] next_remain;

	always_comb
	begin
		next_remain = remain;
		if (load)
			next_remain = count;
		else if (remain != '0)
			next_remain = remain - WIDTH'(1);
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			remain <= '0;
		else
			remain <= next_remain;
	end

	assign busy = (remain != '0);

endmodule // gap_counter

`default_nettype wire

// ===== rtl/sdram_timing_control.sv
// sdram timing control: memory control register, area waits, command gaps, refresh
// assumes a classic wishbone master on the same clock; cycle events from the sdram sequencer
`timescale 1ns/10ps
`default_nettype none

module sdram_timing_control
	import sdram_timing_pkg::*;
(
	input wire logic clock, // 250 MHz bus clock
	input wire logic srst, // power-on reset only
	input wire logic [3:0] wb_adr_i, // byte address
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	input wire logic wb_we_i, // write enable
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	output logic wb_ack_o, // acknowledge
	output logic wb_err_o, // unmapped address
	input wire logic area2IsSdram, // area 2 holds sdram
	input wire logic waitPin, // external wait pin, asynchronous
	input wire logic prechargeDone, // precharge issued
	input wire logic prechargeAll, // precharge was an all-bank refresh precharge
	input wire logic writeEnd, // write cycle ended
	input wire logic autoRefreshCmd, // auto-refresh issued
	input wire logic selfRefreshExit, // memory left self-refresh
	input wire logic bankActivated, // bank-active issued
	input wire logic busCycleActive, // external bus cycle running
	input wire logic refreshTick, // periodic refresh request
	output logic activateAllowed, // bank-active may issue
	output logic rwAllowed, // read/write may issue after activation
	output logic refreshRequest, // pending auto-refresh
	output logic selfRefreshEnter, // enter self-refresh
	output logic inSelfRefresh, // memory in self-refresh
	output logic autoPrecharge, // auto-precharge operation
	output logic [3:0] rowStartSel, // row/column split code
	output logic [3:0] casLatency, // area-2 cas latency
	output logic [3:0] area0FirstWaits, // area-0 first cycle waits
	output logic area0WaitHonoured, // wait pin honoured now
	output logic [3:0] area0BurstStates // states per burst beat
);

	mem_ctrl_t memCtrl;
	mem_ctrl_t next_memCtrl;
	logic [4:0] waitCtrl;
	logic [4:0] next_waitCtrl;
	logic ack;
	logic next_ack;
	logic err;
	logic next_err;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic waitMeta;
	logic waitSync;
	logic pendRefresh;
	logic next_pendRefresh;
	logic selfState;
	logic next_selfState;
	logic selfEnter;
	logic next_selfEnter;
	wait_timing_t timing;
	wait_timing_t next_timing;
	logic actOk;
	logic rwOk;
	logic [3:0] gapCount;
	logic gapLoad;
	logic gapBusy;
	logic rcdBusy;
	logic [3:0] prechargeNormal;

	wire logic access = wb_cyc_i && wb_stb_i && !ack && !err;
	wire logic mapped = (wb_adr_i == MEM_CTRL_ADDR) || (wb_adr_i == WAIT_CTRL_ADDR)
		|| (wb_adr_i == STATUS_ADDR);

	// register bus: one-cycle answer, reserved bit forced low
	always_comb
	begin
		next_memCtrl = memCtrl;
		next_waitCtrl = waitCtrl;
		next_ack = 1'b0;
		next_err = 1'b0;
		next_rdata = rdata;
		if (access)
		begin
			next_ack = mapped;
			next_err = !mapped;
			next_rdata = 32'h00000000;
			if (wb_we_i && wb_adr_i == MEM_CTRL_ADDR)
			begin
				if (wb_sel_i[0])
					next_memCtrl[7:0] = wb_dat_i[7:0] & MEM_CTRL_WRITABLE[7:0];
				if (wb_sel_i[1])
					next_memCtrl[15:8] = wb_dat_i[15:8];
			end
			if (wb_we_i && wb_adr_i == WAIT_CTRL_ADDR && wb_sel_i[0])
				next_waitCtrl = wb_dat_i[4:0];
			if (!wb_we_i)
			begin
				case (wb_adr_i)
					MEM_CTRL_ADDR: next_rdata = {16'h0000, memCtrl & MEM_CTRL_WRITABLE};
					WAIT_CTRL_ADDR: next_rdata = {27'h0000000, waitCtrl};
					STATUS_ADDR: next_rdata = {28'h0000000, selfState, pendRefresh, gapBusy, rcdBusy};
					default: next_rdata = 32'h00000000;
				endcase
			end
		end
	end

	// only power-on reset reaches here; no manual or standby clear
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			memCtrl <= MEM_CTRL_RESET;
			waitCtrl <= WAIT_CTRL_RESET;
			ack <= 1'b0;
			err <= 1'b0;
			rdata <= 32'h00000000;
		end
		else
		begin
			memCtrl <= next_memCtrl;
			waitCtrl <= next_waitCtrl;
			ack <= next_ack;
			err <= next_err;
			rdata <= next_rdata;
		end
	end

	// wait pin crosses in from outside the clock domain
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			waitMeta <= 1'b0;
			waitSync <= 1'b0;
		end
		else
		begin
			waitMeta <= waitPin;
			waitSync <= waitMeta;
		end
	end

	// area wait decode
	always_comb
	begin
		next_timing.casLatency = 4'h3;
		case (waitCtrl[4:3])
			2'b00: next_timing.casLatency = 4'h1;
			2'b01: next_timing.casLatency = 4'h1;
			2'b10: next_timing.casLatency = 4'h2;
			2'b11: next_timing.casLatency = 4'h3;
			default: next_timing.casLatency = 4'h3;
		endcase
		if (!area2IsSdram)
			next_timing.casLatency = 4'h0;
		case (waitCtrl[2:0])
			3'b000: {next_timing.area0FirstWaits, next_timing.area0BurstStates} = {4'h0, 4'h2};
			3'b001: {next_timing.area0FirstWaits, next_timing.area0BurstStates} = {4'h1, 4'h2};
			3'b010: {next_timing.area0FirstWaits, next_timing.area0BurstStates} = {4'h2, 4'h3};
			3'b011: {next_timing.area0FirstWaits, next_timing.area0BurstStates} = {4'h3, 4'h4};
			3'b100: {next_timing.area0FirstWaits, next_timing.area0BurstStates} = {4'h4, 4'h4};
			3'b101: {next_timing.area0FirstWaits, next_timing.area0BurstStates} = {4'h6, 4'h6};
			3'b110: {next_timing.area0FirstWaits, next_timing.area0BurstStates} = {4'h8, 4'h8};
			default: {next_timing.area0FirstWaits, next_timing.area0BurstStates} = {4'hA, 4'hA};
		endcase
		// one flag for first cycle and burst beats; pin honoured only when code nonzero
		next_timing.area0WaitPinUsed = waitSync && (waitCtrl[2:0] != 3'b000);
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			timing <= '0;
		else
			timing <= next_timing;
	end

	// command gap selection
	always_comb
	begin
		prechargeNormal = {2'b00, memCtrl.prechargeGap} + 4'h1;
		gapLoad = 1'b1;
		gapCount = prechargeNormal;
		if (selfRefreshExit)
			gapCount = SELF_EXIT_BASE + SELF_EXIT_STEP * {2'b00, memCtrl.prechargeGap};
		else if (autoRefreshCmd)
			gapCount = prechargeNormal + REFRESH_ACT_BASE + {2'b00, memCtrl.refreshActiveGap};
		else if (writeEnd)
			gapCount = prechargeNormal + {2'b00, memCtrl.writeRecovery} + 4'h1;
		else if (prechargeDone && (prechargeAll || memCtrl.bankOpenMode))
			gapCount = {2'b00, memCtrl.prechargeGap};
		else if (prechargeDone)
			gapCount = prechargeNormal;
		else
			gapLoad = 1'b0;
	end

	// the event cycle is the first held-off cycle, so the counter runs n-1 more
	gap_counter #(.WIDTH(4)) actGap (
		.clock(clock),
		.srst(srst),
		.load(gapLoad && gapCount != 4'h0),
		.count(gapCount - 4'h1),
		.busy(gapBusy)
	);

	gap_counter #(.WIDTH(4)) rcdGap (
		.clock(clock),
		.srst(srst),
		.load(bankActivated),
		.count({2'b00, memCtrl.rowToColDelay}),
		.busy(rcdBusy)
	);

	// refresh handling
	always_comb
	begin
		next_pendRefresh = pendRefresh;
		next_selfState = selfState;
		next_selfEnter = 1'b0;
		if (!memCtrl.refreshOn)
		begin
			next_pendRefresh = 1'b0;
			next_selfState = 1'b0;
		end
		else if (memCtrl.refreshKind)
		begin
			next_pendRefresh = 1'b0;
			if (!selfState && !busCycleActive)
			begin
				next_selfState = 1'b1;
				next_selfEnter = 1'b1;
			end
		end
		else
		begin
			next_selfState = 1'b0;
			// set wins over the clear of a served refresh
			if (refreshTick)
				next_pendRefresh = 1'b1;
			else if (autoRefreshCmd)
				next_pendRefresh = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			pendRefresh <= 1'b0;
			selfState <= 1'b0;
			selfEnter <= 1'b0;
			actOk <= 1'b0;
			rwOk <= 1'b0;
		end
		else
		begin
			pendRefresh <= next_pendRefresh;
			selfState <= next_selfState;
			selfEnter <= next_selfEnter;
			actOk <= !gapBusy && !(gapLoad && gapCount != 4'h0);
			rwOk <= !rcdBusy && !bankActivated;
		end
	end

	assign wb_dat_o = rdata;
	assign wb_ack_o = ack;
	assign wb_err_o = err;
	assign activateAllowed = actOk;
	assign rwAllowed = rwOk;
	// request raised as soon as pending, whether or not a bus cycle runs
	assign refreshRequest = pendRefresh;
	assign selfRefreshEnter = selfEnter;
	assign inSelfRefresh = selfState;
	assign autoPrecharge = !memCtrl.bankOpenMode;
	assign rowStartSel = memCtrl.addrSplit;
	assign casLatency = timing.casLatency;
	assign area0FirstWaits = timing.area0FirstWaits;
	assign area0WaitHonoured = timing.area0WaitPinUsed;
	assign area0BurstStates = timing.area0BurstStates;

endmodule // sdram_timing_control

`default_nettype wire

// ===== dv/sdram_timing_chk.sv
// checker for sdram_timing_control: reset values, decodes, gap starts
// assumes one clock domain; area 2 held as sdram by the bench
`timescale 1ns/10ps
`default_nettype none

module sdram_timing_chk
	import sdram_timing_pkg::*;
(
	input wire logic clock, // clock
	input wire logic srst, // reset
	input wire logic [3:0] wb_adr_i, // address
	input wire logic wb_we_i, // write
	input wire logic [31:0] wb_dat_o, // data
	input wire logic wb_ack_o, // ack
	input wire logic prechargeDone, // precharge
	input wire logic prechargeAll, // all-bank
	input wire logic bankActivated, // activate
	input wire logic autoRefreshCmd, // refresh
	input wire logic selfRefreshExit, // self exit
	input wire logic activateAllowed, // act gate
	input wire logic rwAllowed, // rw gate
	input wire logic autoPrecharge, // auto mode
	input wire logic [3:0] rowStartSel, // split
	input wire logic [3:0] casLatency, // cas
	input wire logic [3:0] area0FirstWaits, // waits
	input wire logic [3:0] area0BurstStates // burst
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (srst);

	AST_SPARE_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> !wb_dat_o[0])
		else $error("spare bit read as one");
	AST_RESET_MC: assert property ($fell(srst) |-> rowStartSel == 4'h0 && autoPrecharge)
		else $error("control register not clear after reset");
	AST_CAS_RESET: assert property ($fell(srst) |=> casLatency == 4'h3)
		else $error("cas latency not three after reset");
	AST_A0_RESET: assert property ($fell(srst) |=> area0FirstWaits == 4'hA)
		else $error("area 0 waits not ten after reset");
	AST_BURST: assert property (area0FirstWaits >= 4'h4 |-> area0BurstStates == area0FirstWaits)
		else $error("burst states differ from first waits");
	AST_PRE_GAP: assert property (prechargeDone && !prechargeAll && autoPrecharge |=> !activateAllowed)
		else $error("activate open right after precharge");
	AST_RCD: assert property (bankActivated |=> !rwAllowed)
		else $error("read or write open right after activate");
	AST_REFRESH_GAP: assert property (autoRefreshCmd |=> !activateAllowed [*3])
		else $error("activate open too soon after refresh");
	AST_SELF_GAP: assert property (selfRefreshExit |=> !activateAllowed [*2])
		else $error("activate open too soon after self exit");
endmodule // sdram_timing_chk

bind sdram_timing_control sdram_timing_chk u_chk (.clock, .srst, .wb_adr_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
	.prechargeDone, .prechargeAll, .bankActivated, .autoRefreshCmd, .selfRefreshExit, .activateAllowed,
	.rwAllowed, .autoPrecharge, .rowStartSel, .casLatency, .area0FirstWaits, .area0BurstStates);

`default_nettype wire

// ===== dv/sdram_side.sv
// far-side model: sequencer events and the wait line
// assumes the bench raises fire for one cycle per event
`timescale 1ns/10ps
`default_nettype none

module sdram_side
	import sdram_timing_pkg::*;
(
	input wire logic clock, // clock
	input wire logic fire, // issue event
	input wire logic [2:0] kind, // which event
	output logic prechargeDone, // precharge
	output logic prechargeAll, // all-bank
	output logic writeEnd, // write over
	output logic autoRefreshCmd, // refresh
	output logic selfRefreshExit, // self exit
	output logic bankActivated, // activate
	output logic waitPin // wait line
);
	// wait line never settles, so the sync path sees real edges
	always @(posedge clock) waitPin <= (waitPin !== 1'b1);
	assign prechargeDone = fire && (kind == GAP_NORMAL || kind == GAP_REFRESH_PRE || kind == GAP_BANK_PRE);
	assign prechargeAll = fire && kind == GAP_REFRESH_PRE;
	assign writeEnd = fire && kind == GAP_WRITE;
	assign autoRefreshCmd = fire && kind == GAP_AUTO_REFRESH;
	assign selfRefreshExit = fire && kind == GAP_SELF_EXIT;
	assign bankActivated = fire && kind == 3'h6;
endmodule // sdram_side

`default_nettype wire

// ===== dv/sdram_timing_control_tb.sv
// bench for sdram_timing_control: registers, decodes, gaps, refresh
// assumes sdram_side as far side and the bound checker
`timescale 1ns/10ps
`default_nettype none

module sdram_timing_control_tb
	import sdram_timing_pkg::*;
;
	logic clock = 0, srst = 1, we = 0, cyc = 0, stb = 0, fire = 0, busy = 1, tick = 0, be;
	logic ack, err, act, rw, rq, ent, slf, ap, wh, pd, pa, wend, ar, sx, ba, wp;
	logic [2:0] kind = '0;
	logic [3:0] adr = '0, rs, cas, fw, bs;
	logic [15:0] m;
	logic [31:0] wd = '0, rd, q, lf = 32'hE8CD;
	int failCount = 0, checkCount = 0;
	localparam logic [3:0] FW[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA};
	localparam logic [3:0] BS[8] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h8, 4'hA};

	always #2 clock = ~clock;

	sdram_side far (.clock, .fire, .kind, .prechargeDone(pd), .prechargeAll(pa), .writeEnd(wend),
		.autoRefreshCmd(ar), .selfRefreshExit(sx), .bankActivated(ba), .waitPin(wp));
	sdram_timing_control dut (.clock, .srst, .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rd), .wb_we_i(we),
		.wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err),
		.area2IsSdram(1'b1), .waitPin(wp), .prechargeDone(pd), .prechargeAll(pa), .writeEnd(wend),
		.autoRefreshCmd(ar), .selfRefreshExit(sx), .bankActivated(ba), .busCycleActive(busy),
		.refreshTick(tick), .activateAllowed(act), .rwAllowed(rw), .refreshRequest(rq),
		.selfRefreshEnter(ent), .inSelfRefresh(slf), .autoPrecharge(ap), .rowStartSel(rs),
		.casLatency(cas), .area0FirstWaits(fw), .area0WaitHonoured(wh), .area0BurstStates(bs));

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checkCount++;
		if (g !== e)
		begin
			failCount++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		adr <= a;
		we <= w;
		wd <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack !== 1'b1 && err !== 1'b1 && n < 50);
		if (ack !== 1'b1 && err !== 1'b1)
		begin
			failCount++;
			$display("CHECK FAILED %0t no bus answer", $time);
		end
		q = rd;
		be = err;
		cyc <= 0;
		stb <= 0;
		@(posedge clock);
	endtask

	// counts low cycles of the chosen gate after one event
	task automatic gap(input logic [2:0] k, input int e, input logic useAct);
		int n;
		n = 0;
		fire <= 1;
		kind <= k;
		@(posedge clock);
		fire <= 0;
		repeat (20)
		begin
			@(posedge clock);
			if ((useAct ? act : rw) !== 1'b1) n++;
		end
		chk(n, e);
	endtask

	task automatic pulse();
		tick <= 1;
		@(posedge clock);
		tick <= 0;
		@(posedge clock);
	endtask

	task results;
		if (failCount == 0 && checkCount > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#40000;
		failCount++;
		results();
	end

	initial
	begin
		repeat (8) @(posedge clock);
		srst <= 0;
		@(posedge clock);
		bus(4'h0, 0, 0);
		chk(q, 0);
		bus(4'h4, 0, 0);
		chk({cas, fw, bs}, 12'h3AA);
		bus(4'hC, 0, 0);
		chk(be, 1);
		for (int i = 0; i < 32; i++)
		begin
			bus(4'h4, 1, i);
			@(posedge clock);
			chk({cas, fw, bs}, {i[4] ? {2'h0, i[4:3]} : 4'h1, FW[i[2:0]], BS[i[2:0]]});
			if (i[2:0] == 3'h0)
				chk(wh, 0);
		end
		for (int p = 0; p < 4; p++)
		begin
			lf = nxt(lf);
			m = {p[1:0], lf[1:0], lf[3:2] % 2'h3, lf[5:4], 1'b0, SPLIT_A10_16, 3'h0};
			bus(4'h0, 1, {16'h0, m | 16'h1});
			bus(4'h0, 0, 0);
			chk(q, m);
			@(posedge clock);
			chk({ap, rs}, {1'b1, SPLIT_A10_16});
			gap(GAP_NORMAL, p + 1, 1);
			gap(GAP_REFRESH_PRE, p, 1);
			gap(GAP_SELF_EXIT, 3 * p + 2, 1);
			gap(GAP_WRITE, p + 2 + m[11:10], 1);
			gap(GAP_AUTO_REFRESH, p + 3 + m[9:8], 1);
			gap(3'h6, m[13:12] + 1, 0);
			if (p != 1)
			begin
				bus(4'h0, 1, {16'h0, m | 16'h80});
				@(posedge clock);
				chk(ap, 0);
				gap(GAP_BANK_PRE, p, 1);
			end
		end
		bus(4'h0, 1, {16'h0, m | 16'h4});
		pulse();
		chk(rq, 1);
		gap(GAP_AUTO_REFRESH, 6 + m[9:8], 1);
		chk(rq, 0);
		bus(4'h0, 1, {16'h0, m | 16'h6});
		repeat (3) @(posedge clock);
		chk(slf, 0);
		busy <= 0;
		repeat (3) @(posedge clock);
		chk(slf, 1);
		pulse();
		chk(rq, 0);
		results();
	end
endmodule // sdram_timing_control_tb

`default_nettype wire
